//--- inc/dct_defines.vh
// timing constants for the ddr2 command spacing controller
`ifndef DCT_DEFINES_VH
`define DCT_DEFINES_VH
`define DCT_CLK_PS 40000
`define DCT_WTR_PS 7500
`define DCT_RTP_PS 7500
`define DCT_XSNR_EXTRA_PS 10000
`define DCT_RFC_PS 127500
`define DCT_RAS_MIN_PS 45000
`define DCT_RAS_MAX_PS 70000000
`define DCT_IS_PS 200
`define DCT_IH_PS 275
`define DCT_XSRD_CK 8'hc8
`define DCT_XP_CK 8'h02
`define DCT_XARD_CK 8'h02
`define DCT_XARDS_SLOW_CK 8'h07
`define DCT_XARDS_FAST_CK 8'h08
`define DCT_CKE_CK 8'h03
`define DCT_ANPD_CK 8'h03
`define DCT_AXPD_CK 8'h08
`define DCT_MRD_CK 8'h02
`define DCT_MR_PDX_BIT 12
`define DCT_EMR_DQS_BIT 10
`define DCT_CMD_NOP 3'h0
`define DCT_CMD_ACT 3'h1
`define DCT_CMD_RD 3'h2
`define DCT_CMD_WR 3'h3
`define DCT_CMD_PRE 3'h4
`define DCT_CMD_MRS 3'h5
`define DCT_CMD_EMRS 3'h6
`define DCT_CMD_REF 3'h7
`define DCT_ST_IDLE 2'h0
`define DCT_ST_SREF 2'h1
`define DCT_ST_PPD 2'h2
`define DCT_ST_APD 2'h3
`endif

//--- hw/dct_ctrl.v
// ddr2 command spacing and power-state timing controller
// What this block does
// - hold reads until write-to-read gap expires
// - hold precharge until read-to-precharge gap expires
// - self refresh exit: refresh time plus 10ns
// - self refresh exit: 200 cycles before read
// - precharge power down exit: 2 cycles
// - fast active power down exit: 2 cycles
// - slow exit: 7 or 8 minus additive latency
// - clock enable held 3 cycles each level
// - termination low 3 cycles before power down
// - 8 cycles after exit before termination timing
// - clock keeps running 3 cycles after clock enable drops, then stops
// - mode bit 12 picks fast or slow exit
// - read to precharge: latency plus half burst
// - 2 cycles after mode set command
// - row active at least 45ns; rows open past 70000ns flagged on row_expired
`timescale 1ns/1ps
`include "dct_defines.vh"
module dct_ctrl #(
    parameter CLK_PS = `DCT_CLK_PS,
    parameter RFC_PS = `DCT_RFC_PS,
    parameter RAS_MAX_PS = `DCT_RAS_MAX_PS,
    parameter FAST_GRADE = 0,
    parameter BANKS = 8
) (
    // clock and reset
    clk,
    rst_n,
    ce,
    // user command request
    req_valid,
    req_cmd,
    req_bank,
    req_addr,
    req_ready,
    // power state requests
    sref_enter,
    pd_enter,
    pd_exit,
    odt_req,
    // configuration
    additive_latency,
    burst_length,
    // memory pins
    mem_cke,
    mem_cmd,
    mem_bank,
    mem_addr,
    mem_odt,
    mem_clk_en,
    // status
    row_expired,
    odt_sync_ok,
    strobe_diff,
    cal_ready
);
    input wire clk;
    input wire rst_n;
    input wire ce;
    input wire req_valid;
    input wire [2:0] req_cmd;
    input wire [2:0] req_bank;
    input wire [13:0] req_addr;
    output wire req_ready;
    input wire sref_enter;
    input wire pd_enter;
    input wire pd_exit;
    input wire odt_req;
    input wire [2:0] additive_latency;
    input wire [3:0] burst_length;
    output reg mem_cke;
    output reg [2:0] mem_cmd;
    output reg [2:0] mem_bank;
    output reg [13:0] mem_addr;
    output reg mem_odt;
    output reg mem_clk_en;
    output reg [BANKS-1:0] row_expired;
    output reg odt_sync_ok;
    output reg strobe_diff;
    output reg cal_ready;

    // ns limits into cycles, rounded up, except the row active maximum, which is rounded down
    localparam integer WTR_CK = (`DCT_WTR_PS + CLK_PS - 1) / CLK_PS;
    localparam integer RTP_CK = (`DCT_RTP_PS + CLK_PS - 1) / CLK_PS;
    localparam integer XSNR_CK = (RFC_PS + `DCT_XSNR_EXTRA_PS + CLK_PS - 1) / CLK_PS;
    localparam integer RASMIN_CK = (`DCT_RAS_MIN_PS + CLK_PS - 1) / CLK_PS;
    localparam integer RASMAX_CK = RAS_MAX_PS / CLK_PS;
    localparam integer HOLD_CK = (`DCT_IS_PS + CLK_PS + `DCT_IH_PS + CLK_PS - 1) / CLK_PS;
    localparam integer XARDS_BASE = FAST_GRADE ? `DCT_XARDS_FAST_CK : `DCT_XARDS_SLOW_CK;

    function [7:0] sat_dec;
        input [7:0] v;
        begin
            sat_dec = (v == 8'h00) ? 8'h00 : v - 8'h01;
        end
    endfunction

    function [7:0] max8;
        input [7:0] a;
        input [7:0] b;
        begin
            max8 = (a > b) ? a : b;
        end
    endfunction

    reg [1:0] st_q;
    reg slow_exit_q;
    reg [7:0] wtr_q;
    reg [7:0] any_q;
    reg [7:0] rd_q;
    reg [7:0] cke_q;
    reg [7:0] odtoff_q;
    reg [7:0] axpd_q;
    reg [7:0] hold_q;
    reg [7:0] pre_q [0:BANKS-1];
    reg [7:0] rasmin_q [0:BANKS-1];
    reg [23:0] rasmax_q [0:BANKS-1];
    reg [BANKS-1:0] open_q;
    reg [2:0] b_q;

    wire [7:0] burst_half = {5'h00, burst_length[3:1]};
    wire [7:0] al8 = {5'h00, additive_latency};
    wire [7:0] rd_pre_ck = max8(al8 + burst_half, RTP_CK[7:0]);
    wire [7:0] slow_ck = (XARDS_BASE[7:0] > al8) ? XARDS_BASE[7:0] - al8 : 8'h01;

    wire is_rd = req_cmd == `DCT_CMD_RD;
    wire is_pre = req_cmd == `DCT_CMD_PRE;
    wire bank_ok = !is_pre || (pre_q[req_bank] == 8'h00 && rasmin_q[req_bank] == 8'h00);
    wire can_issue = (st_q == `DCT_ST_IDLE) && mem_cke && any_q == 8'h00 &&
        (!is_rd || (rd_q == 8'h00 && wtr_q == 8'h00)) && bank_ok;
    assign req_ready = can_issue;
    wire fire = ce && req_valid && can_issue;
    // enter only after odt low long enough and cke pulse met
    wire enter_ok = (st_q == `DCT_ST_IDLE) && mem_cke && cke_q == 8'h00 &&
        odtoff_q >= `DCT_ANPD_CK && any_q == 8'h00 && !req_valid && !odt_req;

    integer i;
    always @(posedge clk) begin
        if (!rst_n) begin
            st_q <= `DCT_ST_IDLE;
            slow_exit_q <= 1'b0;
            wtr_q <= 8'h00;
            any_q <= 8'h00;
            rd_q <= 8'h00;
            cke_q <= 8'h00;
            odtoff_q <= 8'h00;
            axpd_q <= 8'h00;
            hold_q <= 8'h00;
            open_q <= {BANKS{1'b0}};
            b_q <= 3'h0;
            mem_cke <= 1'b1;
            mem_cmd <= `DCT_CMD_NOP;
            mem_bank <= 3'h0;
            mem_addr <= 14'h0000;
            mem_odt <= 1'b0;
            mem_clk_en <= 1'b1;
            row_expired <= {BANKS{1'b0}};
            odt_sync_ok <= 1'b1;
            strobe_diff <= 1'b1;
            cal_ready <= 1'b0;
            for (i = 0; i < BANKS; i = i + 1) begin
                pre_q[i] <= 8'h00;
                rasmin_q[i] <= 8'h00;
                rasmax_q[i] <= 24'h000000;
            end
        end else if (ce) begin
            wtr_q <= sat_dec(wtr_q);
            any_q <= sat_dec(any_q);
            rd_q <= sat_dec(rd_q);
            cke_q <= sat_dec(cke_q);
            axpd_q <= sat_dec(axpd_q);
            hold_q <= sat_dec(hold_q);
            odt_sync_ok <= (axpd_q <= 8'h01);
            cal_ready <= 1'b0;
            mem_cmd <= `DCT_CMD_NOP;
            for (i = 0; i < BANKS; i = i + 1) begin
                pre_q[i] <= sat_dec(pre_q[i]);
                rasmin_q[i] <= sat_dec(rasmin_q[i]);
                if (open_q[i] && rasmax_q[i] != 24'h000000)
                    rasmax_q[i] <= rasmax_q[i] - 24'h000001;
                row_expired[i] <= open_q[i] && rasmax_q[i] <= 24'h000001;
            end
            // odt low counter, counting on in power down, where odt is held off
            if (odt_req && st_q == `DCT_ST_IDLE && mem_cke && axpd_q == 8'h00) begin
                mem_odt <= 1'b1;
                odtoff_q <= 8'h00;
            end else begin
                mem_odt <= 1'b0;
                if (odtoff_q != 8'hff)
                    odtoff_q <= odtoff_q + 8'h01;
            end
            if (hold_q == 8'h01)
                mem_clk_en <= 1'b0;
            if (fire) begin
                mem_cmd <= req_cmd;
                mem_bank <= req_bank;
                mem_addr <= req_addr;
                case (req_cmd)
                    `DCT_CMD_WR: begin
                        wtr_q <= max8(wtr_q, al8 + burst_half + 8'h04 + WTR_CK[7:0]);
                    end
                    `DCT_CMD_RD: begin
                        pre_q[req_bank] <= rd_pre_ck;
                    end
                    `DCT_CMD_ACT: begin
                        open_q[req_bank] <= 1'b1;
                        rasmin_q[req_bank] <= RASMIN_CK[7:0];
                        rasmax_q[req_bank] <= RASMAX_CK[23:0];
                    end
                    `DCT_CMD_PRE: begin
                        open_q[req_bank] <= 1'b0;
                    end
                    `DCT_CMD_MRS: begin
                        any_q <= `DCT_MRD_CK;
                        slow_exit_q <= req_addr[`DCT_MR_PDX_BIT];
                    end
                    `DCT_CMD_EMRS: begin
                        any_q <= `DCT_MRD_CK;
                        strobe_diff <= !req_addr[`DCT_EMR_DQS_BIT];
                        cal_ready <= 1'b1;
                    end
                    default: begin
                        any_q <= any_q;
                    end
                endcase
            end else if (enter_ok && (sref_enter || pd_enter)) begin
                mem_cke <= 1'b0;
                mem_cmd <= sref_enter ? `DCT_CMD_REF : `DCT_CMD_NOP;
                cke_q <= `DCT_CKE_CK;
                hold_q <= HOLD_CK[7:0] + 8'h01;
                st_q <= sref_enter ? `DCT_ST_SREF : ((|open_q) ? `DCT_ST_APD : `DCT_ST_PPD);
            end else if (st_q != `DCT_ST_IDLE && pd_exit && cke_q == 8'h00) begin
                mem_cke <= 1'b1;
                mem_clk_en <= 1'b1;
                hold_q <= 8'h00;
                cke_q <= `DCT_CKE_CK;
                axpd_q <= `DCT_AXPD_CK;
                odt_sync_ok <= 1'b0;
                st_q <= `DCT_ST_IDLE;
                case (st_q)
                    `DCT_ST_SREF: begin
                        any_q <= XSNR_CK[7:0];
                        rd_q <= `DCT_XSRD_CK;
                    end
                    `DCT_ST_PPD: begin
                        any_q <= `DCT_XP_CK;
                    end
                    default: begin
                        any_q <= `DCT_XP_CK;
                        rd_q <= slow_exit_q ? slow_ck : `DCT_XARD_CK;
                    end
                endcase
            end
        end
    end
endmodule

//--- sim/dct_monitor.sv
// assertions on the command spacing controller pins
`timescale 1ns/1ps
module dct_monitor (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // memory pins and status
    input logic mem_cke,
    input logic [2:0] mem_cmd,
    input logic [2:0] mem_bank,
    input logic mem_odt,
    input logic mem_clk_en,
    input logic odt_sync_ok
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wtr_gap_a:
        assert property (mem_cmd == 3'h3 |=> (mem_cmd != 3'h2) [*6]) else $error("early read");
    rtp_gap_a:
        assert property (mem_cmd inside {3'h1, 3'h2} |=>
            !(mem_cmd == 3'h4 && mem_bank == $past(mem_bank))) else $error("early pre");
    mrs_gap_a:
        assert property (mem_cmd == 3'h5 |=> mem_cmd == 3'h0) else $error("early after mrs");
    cke_low_a:
        assert property ($fell(mem_cke) |=> !mem_cke [*2]) else $error("short cke low");
    odt_off_a:
        assert property ($fell(mem_cke) |-> !mem_odt && !$past(mem_odt) && !$past(mem_odt, 2)
            && !$past(mem_odt, 3)) else $error("odt high at entry");
    clk_hold_a:
        assert property ($fell(mem_cke) |-> mem_clk_en ##1 mem_clk_en) else $error("clock cut");
    exit_gap_a:
        assert property ($rose(mem_cke) |-> (mem_cmd == 3'h0) [*2]) else $error("early exit cmd");
    odt_sync_a:
        assert property ($rose(mem_cke) |-> !odt_sync_ok [*8]) else $error("odt sync early");
    cover property ($fell(mem_cke));
    cover property (mem_cmd == 3'h3 ##[1:30] mem_cmd == 3'h2);
    cover property ($rose(mem_cke) ##[2:300] mem_cmd == 3'h2);
endmodule
bind dct_ctrl dct_monitor u_dct_monitor (.clk, .rst_n, .mem_cke, .mem_cmd, .mem_bank, .mem_odt,
    .mem_clk_en, .odt_sync_ok);

//--- sim/dct_dev_model.sv
// behavioural memory device seen at the controller pins
`timescale 1ns/1ps
module dct_dev_model (
    // pins from the controller
    input logic clk,
    input logic mem_cke,
    input logic [2:0] mem_cmd,
    input logic [13:0] mem_addr,
    input logic mem_clk_en,
    // device state
    output logic dqs_diff = 1,
    output logic slow_exit = 0,
    output logic drv_out = 0,
    output int bad_cmd = 0
);
    always @(posedge clk) begin
        if (mem_cmd == 3'h5) slow_exit <= mem_addr[12];
        if (mem_cmd == 3'h6) dqs_diff <= !mem_addr[10];
        if (mem_cmd == 3'h6) drv_out <= #12 1'b1;
        // self refresh entry carries its command with clock enable already low
        if (mem_cmd != 3'h0 && (!mem_clk_en || (!mem_cke && mem_cmd != 3'h7)))
            bad_cmd <= bad_cmd + 1;
    end
endmodule

//--- sim/testbench.sv
// self-checking bench for the command spacing controller
`timescale 1ns/1ps
module testbench;
    logic clk, rst_n, ce, req_valid, req_ready, sref_enter, pd_enter, pd_exit, odt_req;
    logic [2:0] req_cmd, req_bank, additive_latency, mem_cmd, mem_bank, c;
    logic [13:0] req_addr, mem_addr, a;
    logic [3:0] burst_length;
    logic [7:0] row_expired;
    logic mem_cke, mem_odt, mem_clk_en, odt_sync_ok, strobe_diff, cal_ready;
    logic dqs_diff, slow_exit, drv_out, sd_exp, slow_exp;
    int bad_cmd, err_count, compares, cyc, since_up, e;
    int fix_bank = -1;
    int exp_q[$];
    bit [31:0] seed = 41686;
    dct_ctrl #(.RAS_MAX_PS(400000)) u_dct_ctrl (.clk, .rst_n, .ce, .req_valid, .req_cmd,
        .req_bank, .req_addr, .req_ready, .sref_enter, .pd_enter, .pd_exit, .odt_req,
        .additive_latency, .burst_length, .mem_cke, .mem_cmd, .mem_bank, .mem_addr,
        .mem_odt, .mem_clk_en, .row_expired, .odt_sync_ok, .strobe_diff, .cal_ready);
    dct_dev_model u_dct_dev_model (.clk, .mem_cke, .mem_cmd, .mem_addr, .mem_clk_en,
        .dqs_diff, .slow_exit, .drv_out, .bad_cmd);
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    function bit [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, ex, got);
        end
    endtask
    task wrap_up();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // request held until accepted; expected command and minimum gap after cke rise noted
    task issue(input logic [2:0] cm, input logic [13:0] ad, input int g);
        @(posedge clk);
        #1;
        req_valid = 1;
        req_cmd = cm;
        req_addr = ad;
        req_bank = fix_bank < 0 ? 3'(rnd()) : 3'(fix_bank);
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        exp_q.push_back((g << 20) | (req_bank << 17) | (ad << 3) | cm);
        #1;
        req_valid = 0;
    endtask
    task pwr(input bit s);
        @(posedge clk);
        #1;
        odt_req = 0;
        sref_enter = s;
        pd_enter = !s;
        if (s) exp_q.push_back(3'h7);
        while (mem_cke !== 1'b0) @(posedge clk);
        #1;
        sref_enter = 0;
        pd_enter = 0;
        pd_exit = 1;
        while (mem_cke !== 1'b1) @(posedge clk);
        #1;
        pd_exit = 0;
        repeat (2) @(posedge clk);
        #1;
        cmp("odt_sync_ok", 0, odt_sync_ok);
    endtask
    // outputs are looked at mid-cycle, well clear of the edge that launches them
    always @(negedge clk) begin
        if (rst_n && mem_cmd !== 3'h0) begin
            e = exp_q.size() ? exp_q.pop_front() : 0;
            cmp("mem_cmd", e[2:0], mem_cmd);
            if (e[2:0] != 3'h7) begin
                cmp("mem_addr", e[16:3], mem_addr);
                cmp("mem_bank", e[19:17], mem_bank);
            end
            cmp("exit_gap", 1, since_up >= (e >> 20));
            cmp("cal_ready", mem_cmd == 3'h6, cal_ready);
            if (mem_cmd == 3'h6) cmp("strobe_diff", sd_exp, strobe_diff);
        end
        since_up = (mem_cke === 1'b1) ? since_up + 1 : 0;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        {rst_n, req_valid, req_cmd, req_bank, req_addr} = 0;
        {sref_enter, pd_enter, pd_exit, odt_req} = 0;
        ce = 1;
        sd_exp = 1;
        slow_exp = 0;
        additive_latency = 3'(rnd() % 5);
        burst_length = rnd() % 2 ? 4'h8 : 4'h4;
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1;
        cmp("odt_sync_ok", 1, odt_sync_ok);
        cmp("mem_clk_en", 1, mem_clk_en);
        for (int i = 0; i < 40; i++) begin
            c = 3'(1 + rnd() % 7);
            a = 14'(rnd());
            odt_req = 1'(rnd());
            if (c == 3'h6) sd_exp = !a[10];
            if (c == 3'h5) slow_exp = a[12];
            issue(c, a, 0);
        end
        sd_exp = 0;
        issue(3'h6, 14'h0400, 0);
        repeat (3) @(posedge clk);
        #1;
        cmp("strobe_diff", 0, strobe_diff);
        cmp("dqs_diff", 0, dqs_diff);
        cmp("drv_out", 1, drv_out);
        $display("test commands done");
        issue(3'h4, 14'h0400, 0);
        pwr(1);
        fix_bank = 0;
        issue(3'h1, 14'h0000, 4);
        issue(3'h2, 14'h0000, 200);
        fix_bank = -1;
        cmp("odt_sync_ok", 1, odt_sync_ok);
        cmp("row_expired", 1, row_expired[0]);
        $display("test self refresh done");
        cmp("slow_exit", slow_exp, slow_exit);
        pwr(0);
        issue(3'h2, 14'h0000, slow_exp ? 7 - additive_latency : 2);
        for (int b = 0; b < 8; b++) begin
            fix_bank = b;
            issue(3'h4, 14'h0400, 0);
        end
        fix_bank = -1;
        repeat (2) @(posedge clk);
        #1;
        cmp("row_expired", 0, row_expired);
        pwr(0);
        issue(3'h1, 14'h0000, 2);
        repeat (10) @(posedge clk);
        cmp("bad_cmd", 0, bad_cmd);
        $display("test power down done");
        wrap_up();
    end
endmodule
